/* File: pab_cfg.svh */
//==================================================================
// Purpose: constants of the pipelined converter digital back end
// Assumes: one clock, clk_in at 250 MHz, two clock cycles per sample
// Notes:   the package holds the types, this header the numbers
//==================================================================
// Overview of operation
// - Two non-overlapping phases, sample then hold, come from the master clock.
// - A sample is taken as the sample phase ends, and the hold phase completes it.
// - Eight identical stages and a ninth final stage each give a two-bit word.
// - Each stage runs on the inverse phase of the stage before it.
// - Each identical stage word carries one redundant bit for correction.
// - A delay line stepping every clk_in cycle aligns all nine words into 18 bits.
// - Correction merges the aligned 18 bits into one 10-bit result.
// - A result reaches the bus on the seventh sample cycle after its sample.
// - After the latency one new result follows per sample cycle.
// - Results pass two cascaded latch stages on the sample clock.
// - The result is offset binary or two's complement per format select.
// - Format select low gives offset binary, high gives two's complement.
// - Two's complement is offset binary with the top bit inverted.
// - Output enable low drives the data pins, high releases them.
`ifndef PAB_CFG_SVH
`define PAB_CFG_SVH

`define PAB_CLK_PERIOD_NS 4
`define PAB_STAGES 9
`define PAB_WORD_BITS 2
`define PAB_RES_BITS 10
`define PAB_SUM_BITS 11
`define PAB_CODE_MAX 11'h03FF
`define PAB_LATENCY_SAMPLES 7
`define PAB_SETTLE_CYCLES 20
`define PAB_SETTLE_BITS 5
`define PAB_ALIGN_TAP 10
`define PAB_FIFO_DEPTH 32
`define PAB_MSB 9

`endif

/* File: pab_pkg.sv */
//==================================================================
// Purpose: shared types of the converter back end
// Assumes: pab_cfg.svh gives the sizes
// Notes:   none
//==================================================================
`include "pab_cfg.svh"

package pab_pkg;

  // Nine raw two-bit stage words
  typedef logic [`PAB_STAGES-1:0][`PAB_WORD_BITS-1:0] pab_stage_vec_t;

  // One corrected result with its qualifier
  typedef struct packed {
    logic valid;
    logic [`PAB_RES_BITS-1:0] code;
  } pab_result_s;

  // Two-phase sampling clock state
  typedef enum logic [1:0] {
    PAB_PH_SAMPLE = 2'b01,
    PAB_PH_HOLD = 2'b10
  } pab_phase_e;

endpackage : pab_pkg

/* File: pab_fifo.sv */
//==================================================================
// Purpose: result buffer between correction and the output latches
// Assumes: one clock, synchronous active-high reset
// Notes:   writes while full are refused through in_ready_out
//==================================================================
`timescale 1ns/10ps

module pab_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Filling side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Draining side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("pab_fifo: DEPTH must be a power of two, at least 2");
    end
  end

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire logic do_wr;
  wire logic do_rd;

  // Handshake decode
  assign in_ready_out = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];
  assign do_wr = in_valid_in && in_ready_out;
  assign do_rd = out_valid_out && out_ready_in;

  // Storage
  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(do_wr);
      rd_ptr <= rd_ptr + AW'(do_rd);
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

endmodule : pab_fifo

/* File: pab_err_corr.sv */
//==================================================================
// Purpose: merges aligned stage words into a corrected result
// Assumes: input vector is already time aligned
// Notes:   registered, one cycle through
//==================================================================
`timescale 1ns/10ps
`include "pab_cfg.svh"

module pab_err_corr (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Aligned raw words and strobe
  input wire pab_pkg::pab_stage_vec_t raw_in,
  input wire logic raw_valid_in,
  // Corrected result
  output pab_pkg::pab_result_s result_out
);
  import pab_pkg::*;

  // Overlapping weighted sum, saturated at full scale
  function automatic logic [`PAB_RES_BITS-1:0] pab_correct(input pab_stage_vec_t v);
    logic [`PAB_SUM_BITS-1:0] sum;
    sum = '0;
    for (int k = 0; k < `PAB_STAGES; k++) begin
      sum = sum + (`PAB_SUM_BITS'(v[k]) << (`PAB_STAGES - 1 - k));
    end
    if (sum > `PAB_CODE_MAX) begin
      sum = `PAB_CODE_MAX;
    end
    return sum[`PAB_RES_BITS-1:0];
  endfunction : pab_correct

  wire logic [`PAB_RES_BITS-1:0] next_code;

  assign next_code = pab_correct(raw_in);

  // Result register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      result_out <= '0;
    end else begin
      result_out.valid <= raw_valid_in;
      result_out.code <= next_code;
    end
  end

endmodule : pab_err_corr

/* File: pab_backend.sv */
//==================================================================
// Purpose: digital back end of a nine-stage pipelined converter
// Assumes: stage words arrive synchronous to clk_in in their phase
// Notes:   one sample per two clk_in cycles; result on the seventh
//          sample cycle while the capture side keeps up
//==================================================================
`timescale 1ns/10ps
`include "pab_cfg.svh"

module pab_backend #(
  parameter int FIFO_DEPTH = `PAB_FIFO_DEPTH,
  parameter int SETTLE_CYCLES = `PAB_SETTLE_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Raw stage decisions
  input wire pab_pkg::pab_stage_vec_t stage_words_in,
  // Pin controls
  input wire logic format_select_in,
  input wire logic output_enable_n_in,
  input wire logic capture_ready_in,
  // Internal sampling clock
  output logic phase_sample_out,
  output logic phase_hold_out,
  output logic [`PAB_STAGES-1:0] stage_phase_out,
  output logic sample_strobe_out,
  // Output data bus
  output logic [`PAB_RES_BITS-1:0] data_out,
  output logic data_oe_out,
  output logic data_valid_out,
  // Status
  output logic fifo_ready_out,
  output logic overrun_out
);
  import pab_pkg::*;

  initial begin
    if (FIFO_DEPTH < 2 || SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << `PAB_SETTLE_BITS)) begin
      $error("pab_backend: FIFO_DEPTH or SETTLE_CYCLES out of range");
    end
  end

  //================================================================
  // Two-phase sampling clock
  //================================================================
  pab_phase_e phase;
  pab_phase_e next_phase;
  wire logic sample_edge;
  wire logic in_hold;

  // Sample phase always hands over to hold and back
  assign in_hold = (phase == PAB_PH_HOLD);
  assign next_phase = in_hold ? PAB_PH_SAMPLE : PAB_PH_HOLD;
  assign sample_edge = !in_hold;

  // Phase state
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      phase <= PAB_PH_SAMPLE;
    end else begin
      unique case (phase)
        PAB_PH_SAMPLE: begin
          phase <= next_phase;
        end
        PAB_PH_HOLD: begin
          phase <= next_phase;
        end
        default: begin
          phase <= PAB_PH_SAMPLE;
        end
      endcase
    end
  end

  // Phase pins, never high together
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      phase_sample_out <= 1'b0;
      phase_hold_out <= 1'b0;
    end else begin
      phase_sample_out <= (next_phase == PAB_PH_SAMPLE);
      phase_hold_out <= (next_phase == PAB_PH_HOLD);
    end
  end

  // Sample taken as the sample phase closes
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sample_strobe_out <= 1'b0;
    end else begin
      sample_strobe_out <= sample_edge;
    end
  end

  //================================================================
  // Stage clocks
  //================================================================
  wire logic [`PAB_STAGES-1:0] stage_capture;

  // Even stages resolve in hold, odd stages in sample, each inverted
  genvar gs;
  generate
    for (gs = 0; gs < `PAB_STAGES; gs++) begin : g_stage_clk
      assign stage_capture[gs] = in_hold ^ (gs % 2 == 1);
    end
  endgenerate

  // Stage phase pins, one bit per stage
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      stage_phase_out <= '0;
    end else begin
      stage_phase_out <= ~stage_capture;
    end
  end

  //================================================================
  // Delay line
  //================================================================
  pab_stage_vec_t aligned;

  // Stage k is caught in its phase, then waits the stages behind it
  genvar gk;
  generate
    for (gk = 0; gk < `PAB_STAGES; gk++) begin : g_delay
      localparam int LEN = `PAB_STAGES - gk;
      logic [`PAB_WORD_BITS-1:0] line [0:LEN-1];
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          for (int j = 0; j < LEN; j++) begin
            line[j] <= '0;
          end
        end else begin
          if (stage_capture[gk]) begin
            line[0] <= stage_words_in[gk];
          end
          for (int j = 1; j < LEN; j++) begin
            line[j] <= line[j-1];
          end
        end
      end
      assign aligned[gk] = line[LEN-1];
    end
  endgenerate

  //================================================================
  // Sample tracking through the alignment
  //================================================================
  logic [`PAB_ALIGN_TAP-1:0] sample_track;
  wire logic align_valid;

  // A marker travels with each sample until its words line up
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sample_track <= '0;
    end else begin
      sample_track <= {sample_track[`PAB_ALIGN_TAP-2:0], sample_edge};
    end
  end

  assign align_valid = sample_track[`PAB_ALIGN_TAP-1];

  //================================================================
  // Error correction
  //================================================================
  pab_result_s corrected;

  pab_err_corr u_corr (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .raw_in(aligned),
    .raw_valid_in(align_valid),
    .result_out(corrected)
  );

  //================================================================
  // Result buffer
  //================================================================
  wire logic fifo_in_ready;
  wire logic fifo_out_valid;
  wire logic [`PAB_RES_BITS-1:0] fifo_out_data;
  wire logic latch_step;
  wire logic fifo_pop;

  // Latches move on sample edges while the capture side takes data
  assign latch_step = sample_edge && capture_ready_in;
  assign fifo_pop = latch_step && fifo_out_valid;

  pab_fifo #(
    .WIDTH(`PAB_RES_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .in_valid_in(corrected.valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(corrected.code),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_out_data)
  );

  // Buffer status, overrun sticky until reset
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      fifo_ready_out <= 1'b0;
      overrun_out <= 1'b0;
    end else begin
      fifo_ready_out <= fifo_in_ready;
      overrun_out <= overrun_out || (corrected.valid && !fifo_in_ready);
    end
  end

  //================================================================
  // Power-up settling count
  //================================================================
  logic [`PAB_SETTLE_BITS-1:0] settle_count;
  wire logic settled;

  assign settled = (settle_count == `PAB_SETTLE_BITS'(SETTLE_CYCLES));

  // Counts sample cycles since reset, stops at the limit
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      settle_count <= '0;
    end else if (sample_edge && !settled) begin
      settle_count <= settle_count + 1'b1;
    end
  end

  //================================================================
  // Double-buffered output latches
  //================================================================
  pab_result_s latch_one;
  wire logic [`PAB_RES_BITS-1:0] next_data;

  // Format applied on the way out: top bit flipped for two's complement
  assign next_data = {latch_one.code[`PAB_MSB] ^ format_select_in,
                      latch_one.code[`PAB_MSB-1:0]};

  // First latch stage, filled from the buffer
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      latch_one <= '0;
    end else if (latch_step) begin
      latch_one.valid <= fifo_out_valid;
      latch_one.code <= fifo_out_data;
    end
  end

  // Second latch stage drives the bus
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      data_out <= '0;
      data_valid_out <= 1'b0;
    end else if (latch_step) begin
      data_out <= next_data;
      data_valid_out <= latch_one.valid && settled;
    end
  end

  // Output enable, driven while the enable pin is low
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      data_oe_out <= 1'b0;
    end else begin
      data_oe_out <= !output_enable_n_in;
    end
  end

endmodule : pab_backend

/* File: pab_backend_properties.sv */
// ====
// Purpose: port assertions of the converter back end
// Assumes: one clock, synchronous active-high reset
// Notes: bound to pab_backend below the module
`timescale 1ns/10ps
`include "pab_cfg.svh"

module pab_backend_properties #(
  parameter int SETTLE_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Pin controls
  input wire logic output_enable_n_in,
  input wire logic capture_ready_in,
  // Design outputs
  input wire logic phase_sample_out,
  input wire logic phase_hold_out,
  input wire logic [`PAB_STAGES-1:0] stage_phase_out,
  input wire logic sample_strobe_out,
  input wire logic [`PAB_RES_BITS-1:0] data_out,
  input wire logic data_oe_out,
  input wire logic data_valid_out
);
  localparam int VALID_MIN = (2 * SETTLE_CYCLES - 2 > 14) ? 2 * SETTLE_CYCLES - 2 : 14;
  int run_cnt;

  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);

  // Cycles since reset release, saturating
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      run_cnt <= 0;
    end else if (run_cnt < 10000) begin
      run_cnt <= run_cnt + 1;
    end
  end

  // Two running cycles, and a stalled sample edge
  sequence s_run;
    !srst_in ##1 !srst_in;
  endsequence
  sequence s_stall;
    !srst_in ##1 !capture_ready_in ##1 sample_strobe_out;
  endsequence

  AST_PHASE_EXCL: assert property (!(phase_sample_out && phase_hold_out))
    else $error("sample and hold phases overlap");
  AST_PHASE_SWAP: assert property (phase_sample_out |=> phase_hold_out ##1 phase_sample_out)
    else $error("phases do not alternate");
  AST_STROBE_RATE: assert property (sample_strobe_out |=> !sample_strobe_out ##1 sample_strobe_out)
    else $error("sample strobe not every other cycle");
  AST_STAGE_ALT: assert property ((phase_sample_out || phase_hold_out) |->
    (stage_phase_out[8:1] ^ stage_phase_out[7:0]) == 8'hFF)
    else $error("neighbour stages share a phase");
  AST_STAGE_FLIP: assert property (phase_hold_out |=> stage_phase_out == ~$past(stage_phase_out))
    else $error("stage phases did not invert");
  AST_OE_OFF: assert property (output_enable_n_in |=> !data_oe_out)
    else $error("data pins driven while disabled");
  AST_OE_ON: assert property (s_run ##0 !output_enable_n_in |=> data_oe_out)
    else $error("data pins not driven while enabled");
  AST_VALID_WAIT: assert property (data_valid_out |-> run_cnt >= VALID_MIN)
    else $error("data valid before latency and settling");
  AST_DATA_ON_EDGE: assert property (!srst_in ##1 $changed(data_out) |-> sample_strobe_out)
    else $error("data changed off a sample edge");
  AST_STALL_HOLD: assert property (s_stall |-> $stable(data_out) && $stable(data_valid_out))
    else $error("latches advanced while capture stalled");
endmodule : pab_backend_properties

bind pab_backend pab_backend_properties #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_props (
  .clk_in(clk_in), .srst_in(srst_in), .output_enable_n_in(output_enable_n_in),
  .capture_ready_in(capture_ready_in), .phase_sample_out(phase_sample_out), .phase_hold_out(phase_hold_out),
  .stage_phase_out(stage_phase_out), .sample_strobe_out(sample_strobe_out), .data_out(data_out),
  .data_oe_out(data_oe_out), .data_valid_out(data_valid_out));

/* File: pab_capture.sv */
// ====
// Purpose: capture logic on the far side of the data bus
// Assumes: stall comes from the bench at the falling edge
// Notes: ignores words on the first DISCARD_SAMPLES sample edges after reset
`timescale 1ns/10ps
`include "pab_cfg.svh"

module pab_capture #(
  parameter int DISCARD_SAMPLES = 20
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Data pins and qualifiers
  input wire logic [`PAB_RES_BITS-1:0] bus_in,
  input wire logic sample_strobe_in,
  input wire logic data_valid_in,
  // Back-pressure
  input wire logic stall_in,
  output logic capture_ready_out,
  // Captured words
  output logic cap_pulse_out,
  output logic [`PAB_RES_BITS-1:0] cap_word_out
);
  int n_seen;
  logic ready_at_edge;

  // Ready follows the stall request directly
  assign capture_ready_out = !stall_in;

  // One word per sample edge on which the latches advanced
  always @(posedge clk_in) begin
    cap_pulse_out <= 1'b0;
    ready_at_edge <= capture_ready_out;
    if (srst_in) begin
      n_seen <= 0;
    end else if (sample_strobe_in) begin
      if (n_seen < DISCARD_SAMPLES) begin
        n_seen <= n_seen + 1;
      end else if (ready_at_edge && data_valid_in) begin
        cap_pulse_out <= 1'b1;
        cap_word_out <= bus_in;
      end
    end
  end
endmodule : pab_capture

/* File: tb_pab_backend.sv */
// ====
// Purpose: self-checking bench of the converter back end
// Assumes: FIFO depth 4 and settling 2 shorten the run
// Notes: stage words follow each stage's capture edge
`timescale 1ns/10ps
`include "pab_cfg.svh"

module tb_pab_backend;
  import pab_pkg::*;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  pab_stage_vec_t stage_words_in = '0;
  logic format_select_in = 1'b0;
  logic output_enable_n_in = 1'b0;
  logic stall = 1'b0;
  logic capture_ready, phase_sample, phase_hold, sample_strobe, data_oe, data_valid;
  logic fifo_ready, overrun, cap_pulse;
  logic [`PAB_STAGES-1:0] stage_phase;
  logic [`PAB_RES_BITS-1:0] data, cap_word;
  wire [`PAB_RES_BITS-1:0] data_bus;
  int cyc = 0;
  int tick = 0;
  int n_tests = 0;
  int n_errors = 0;
  int sat_lo = -10;

  // Pins float unless the outputs are enabled
  assign data_bus = data_oe ? data : 'z;

  pab_backend #(.FIFO_DEPTH(4), .SETTLE_CYCLES(2)) dut (
    .clk_in(clk_in), .srst_in(srst_in), .stage_words_in(stage_words_in), .format_select_in(format_select_in),
    .output_enable_n_in(output_enable_n_in), .capture_ready_in(capture_ready), .phase_sample_out(phase_sample),
    .phase_hold_out(phase_hold), .stage_phase_out(stage_phase), .sample_strobe_out(sample_strobe),
    .data_out(data), .data_oe_out(data_oe), .data_valid_out(data_valid), .fifo_ready_out(fifo_ready),
    .overrun_out(overrun));

  pab_capture u_cap (
    .clk_in(clk_in), .srst_in(srst_in), .bus_in(data_bus), .sample_strobe_in(sample_strobe),
    .data_valid_in(data_valid), .stall_in(stall), .capture_ready_out(capture_ready),
    .cap_pulse_out(cap_pulse), .cap_word_out(cap_word));

  // Clock
  initial begin
    forever #2 clk_in = ~clk_in;
  end

  // Cycle count from reset release and hang guard
  always @(posedge clk_in) begin
    cyc <= srst_in ? 0 : cyc + 1;
    tick <= tick + 1;
    if (tick == 3000) begin
      n_errors++;
      summarize();
    end
  end

  // Stage word of sample n, a ramp with a saturating window
  function automatic logic [1:0] word_of(int n, int k);
    logic [9:0] t;
    t = 10'(n * 37);
    if (n >= sat_lo && n < sat_lo + 2) return 2'b11;
    if (k == 0) return t[9:8];
    return {1'b0, t[8 - k]};
  endfunction

  // Weighted sum of the nine words, saturated
  function automatic logic [9:0] exp_of(int n);
    int s;
    s = 0;
    for (int k = 0; k < 9; k++) s += int'(word_of(n, k)) << (8 - k);
    return (s > 1023) ? 10'h3FF : 10'(s);
  endfunction

  // Each stage sees its sample's word ahead of its capture edge
  always @(negedge clk_in) begin
    for (int k = 0; k < `PAB_STAGES; k++) begin
      if (cyc > k) stage_words_in[k] <= word_of((cyc - 1 - k) / 2, k);
    end
  end

  task automatic check_val(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic at_cyc(int c);
    while (cyc < c) @(negedge clk_in);
  endtask : at_cyc

  task automatic do_reset();
    srst_in = 1'b1;
    repeat (10) @(negedge clk_in);
    srst_in = 1'b0;
  endtask : do_reset

  task automatic t_latency();
    at_cyc(3);
    check_val("phase", 1, phase_sample ^ phase_hold);
    check_val("stage pattern", 1, stage_phase == 9'h155 || stage_phase == 9'h0AA);
    at_cyc(14);
    check_val("early valid", 0, data_valid);
    at_cyc(15);
    check_val("valid", 1, data_valid);
    check_val("first result", exp_of(0), data);
    at_cyc(17);
    check_val("second result", exp_of(1), data);
    $display("test latency done");
  endtask : t_latency

  task automatic t_stream();
    sat_lo = 30;
    for (int n = 20; n < 34; n++) begin
      at_cyc(2 * n + 14);
      check_val("held result", exp_of(n - 1), data);
      at_cyc(2 * n + 15);
      check_val("result", exp_of(n), data);
    end
    $display("test stream done");
  endtask : t_stream

  task automatic t_format();
    at_cyc(80);
    format_select_in = 1'b1;
    for (int n = 40; n < 44; n++) begin
      at_cyc(2 * n + 15);
      check_val("twos result", exp_of(n) ^ 10'h200, data);
    end
    format_select_in = 1'b0;
    $display("test format done");
  endtask : t_format

  task automatic t_oe();
    output_enable_n_in = 1'b1;
    repeat (2) @(negedge clk_in);
    check_val("oe off", 0, data_oe);
    check_val("bus off", {10{1'bz}}, data_bus);
    output_enable_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    check_val("oe on", 1, data_oe);
    check_val("bus on", exp_of((cyc - 15) / 2), data_bus);
    $display("test enable done");
  endtask : t_oe

  task automatic t_stall();
    logic [9:0] prev;
    int got;
    got = 0;
    prev = '0;
    for (int i = 0; i < 80; i++) begin
      stall = (i >= 20 && i < 26);
      @(negedge clk_in);
      if (cap_pulse === 1'b1) begin
        if (got > 0) check_val("capture order", 10'(prev + 10'd37), cap_word);
        prev = cap_word;
        got++;
      end
    end
    check_val("no refusal", 0, overrun);
    stall = 1'b1;
    repeat (40) @(negedge clk_in);
    check_val("fifo full", 0, fifo_ready);
    check_val("overrun", 1, overrun);
    stall = 1'b0;
    repeat (20) @(negedge clk_in);
    check_val("overrun kept", 1, overrun);
    do_reset();
    @(negedge clk_in);
    check_val("overrun cleared", 0, overrun);
    $display("test stall done");
  endtask : t_stall

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    do_reset();
    t_latency();
    t_stream();
    t_format();
    t_oe();
    t_stall();
    summarize();
  end
endmodule : tb_pab_backend
